// file: logic/srx_cfg.svh
// Function
// - keep 32-bit aborted-byte tally, upper two bytes readable as byte registers
// - tally may count bytes later dropped; no exclusion logic needed
// - request 0 to 1 copies counters to readable copy, then resets them
// - done flag sets after copy completes, clears when request returns to zero
// - bit 3 latches upper SAPI octet mismatch, cleared by read
// - bit 2 latches lower SAPI octet mismatch, cleared by read
// - bit 1 latches control field mismatch, cleared by read
// - bit 0 latches address field mismatch, cleared by read
// - each header mismatch flag interrupts only when same-position enable is set
// - low watermark byte position is register value times 32 times 2048
// - high watermark byte position is register value times 32 times 2048
// - bit 0 latches fill level crossing low watermark, cleared by read
// - bit 1 latches fill level crossing high watermark, cleared by read
// - bit 2 latches transmit queue overflow, cleared by read
// - bit 3 latches staging FIFO overflow, cleared by read
// - enables in bits 3..0 gate the queue flags at same positions
`ifndef SRX_CFG_SVH
`define SRX_CFG_SVH

// register indices; byte address is four times the index
`define SRX_IDX_ABORT_B2 10'h11e
`define SRX_IDX_ABORT_B3 10'h11f
`define SRX_IDX_SNAP_REQ 10'h120
`define SRX_IDX_SNAP_DONE 10'h121
`define SRX_IDX_X86_FLAGS 10'h122
`define SRX_IDX_X86_IRQ_EN 10'h123
`define SRX_IDX_TXQ_LOW 10'h124
`define SRX_IDX_TXQ_HIGH 10'h125
`define SRX_IDX_TXQ_IRQ_EN 10'h126
`define SRX_IDX_TXQ_FLAGS 10'h127

// field positions
`define SRX_BIT_SNAP 0
`define SRX_BIT_ADDR_MM 0
`define SRX_BIT_CTRL_MM 1
`define SRX_BIT_LSAPI_MM 2
`define SRX_BIT_USAPI_MM 3
`define SRX_BIT_LOW_X 0
`define SRX_BIT_HIGH_X 1
`define SRX_BIT_Q_OVF 2
`define SRX_BIT_F_OVF 3

// reset values
`define SRX_RST_BYTE 8'h00
`define SRX_RST_FLAGS 4'h0

// watermark unit: 32 packets of 2048 bytes
`define SRX_MARK_PKTS 32
`define SRX_MARK_PKT_BYTES 2048
`define SRX_MARK_SHIFT 16
`define SRX_LEVEL_W 24

`endif

// file: logic/srx_pkg.sv
package srx_pkg;

typedef logic [7:0] srx_byte_t;
typedef logic [3:0] srx_flags_t;

typedef enum logic [1:0] {
    SRX_IDLE,
    SRX_WR,
    SRX_RD_WAIT,
    SRX_RD_OUT
} srx_bus_e;

endpackage : srx_pkg

// file: logic/srx_regs.sv
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`include "srx_cfg.svh"

module srx_regs (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // receive abort tally
    input wire logic abort_byte_inc,
    output logic [15:0] aborted_byte_tally_low,
    output logic perf_snapshot_strobe,
    // received header check
    input wire logic hdr_valid,
    input wire logic [7:0] hdr_address,
    input wire logic [7:0] hdr_control,
    input wire logic [7:0] received_upper_sapi_octet,
    input wire logic [7:0] received_lower_sapi_octet,
    input wire logic [7:0] expected_address,
    input wire logic [7:0] expected_control,
    input wire logic [7:0] expected_upper_sapi,
    input wire logic [7:0] expected_lower_sapi,
    output logic x86_irq,
    // transmit queue
    input wire logic [23:0] txq_fill_level,
    input wire logic txq_overflow,
    input wire logic staging_fifo_overflow,
    output logic [23:0] queue_low_mark_bytes,
    output logic [23:0] queue_high_mark_bytes,
    output logic txq_irq
);

    srx_pkg::srx_bus_e state_q;
    srx_pkg::srx_bus_e state_d;
    logic [9:0] idx_q;
    logic [31:0] rdata_q;

    srx_pkg::srx_byte_t low_mark_q;
    srx_pkg::srx_byte_t high_mark_q;
    srx_pkg::srx_flags_t x86_en_q;
    srx_pkg::srx_flags_t txq_en_q;
    logic snap_req_q;
    logic snap_req_prev_q;
    logic snap_busy_q;
    logic snap_done_q;

    logic [31:0] tally_q;
    logic [31:0] tally_snap_q;
    logic above_low_q;
    logic above_high_q;
    srx_pkg::srx_flags_t x86_flags_q;
    srx_pkg::srx_flags_t txq_flags_q;

    // bus decode; hsize and the upper data bits go unchecked, every register sits alone in its word
    wire accept = hsel && htrans[1] && hready && (state_q != srx_pkg::SRX_RD_WAIT);
    wire [9:0] addr_idx = haddr[11:2];
    wire wr_en = (state_q == srx_pkg::SRX_WR);
    wire rd_now = (state_q == srx_pkg::SRX_RD_WAIT);
    wire [7:0] wbyte = hwdata[7:0];

    wire wr_snap = wr_en && (idx_q == `SRX_IDX_SNAP_REQ);
    wire wr_x86_en = wr_en && (idx_q == `SRX_IDX_X86_IRQ_EN);
    wire wr_low = wr_en && (idx_q == `SRX_IDX_TXQ_LOW);
    wire wr_high = wr_en && (idx_q == `SRX_IDX_TXQ_HIGH);
    wire wr_txq_en = wr_en && (idx_q == `SRX_IDX_TXQ_IRQ_EN);

    wire rd_x86_flags = rd_now && (idx_q == `SRX_IDX_X86_FLAGS);
    wire rd_txq_flags = rd_now && (idx_q == `SRX_IDX_TXQ_FLAGS);

    // one wait state on reads so a preceding write is always seen
    assign hreadyout = (state_q != srx_pkg::SRX_RD_WAIT);
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_comb
    begin
        state_d = srx_pkg::SRX_IDLE;
        case (state_q)
            srx_pkg::SRX_RD_WAIT:
            begin
                state_d = srx_pkg::SRX_RD_OUT;
            end
            srx_pkg::SRX_IDLE, srx_pkg::SRX_WR, srx_pkg::SRX_RD_OUT:
            begin
                if (accept)
                begin
                    state_d = hwrite ? srx_pkg::SRX_WR : srx_pkg::SRX_RD_WAIT;
                end
            end
            default:
            begin
                state_d = srx_pkg::SRX_IDLE;
            end
        endcase
    end

    // read mux; unmapped indices read zero
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        case (idx_q)
            `SRX_IDX_ABORT_B2: rd_byte = tally_snap_q[23:16];
            `SRX_IDX_ABORT_B3: rd_byte = tally_snap_q[31:24];
            `SRX_IDX_SNAP_REQ: rd_byte = {7'h00, snap_req_q};
            `SRX_IDX_SNAP_DONE: rd_byte = {7'h00, snap_done_q};
            `SRX_IDX_X86_FLAGS: rd_byte = {4'h0, x86_flags_q};
            `SRX_IDX_X86_IRQ_EN: rd_byte = {4'h0, x86_en_q};
            `SRX_IDX_TXQ_LOW: rd_byte = low_mark_q;
            `SRX_IDX_TXQ_HIGH: rd_byte = high_mark_q;
            `SRX_IDX_TXQ_IRQ_EN: rd_byte = {4'h0, txq_en_q};
            `SRX_IDX_TXQ_FLAGS: rd_byte = {4'h0, txq_flags_q};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q <= srx_pkg::SRX_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            idx_q <= 10'h000;
        end
        else if (accept)
        begin
            idx_q <= addr_idx;
        end
    end

    // captured in the stall cycle, on the same edge that clears any read flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (rd_now)
        begin
            rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // writable registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            low_mark_q <= `SRX_RST_BYTE;
        end
        else if (wr_low)
        begin
            low_mark_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            high_mark_q <= `SRX_RST_BYTE;
        end
        else if (wr_high)
        begin
            high_mark_q <= wbyte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            x86_en_q <= `SRX_RST_FLAGS;
        end
        else if (wr_x86_en)
        begin
            x86_en_q <= wbyte[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            txq_en_q <= `SRX_RST_FLAGS;
        end
        else if (wr_txq_en)
        begin
            txq_en_q <= wbyte[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            snap_req_q <= 1'b0;
        end
        else if (wr_snap)
        begin
            snap_req_q <= wbyte[`SRX_BIT_SNAP];
        end
    end

    // snapshot: copy and restart happen in one edge, done follows one edge later
    wire snap_pulse = snap_req_q && !snap_req_prev_q;
    assign perf_snapshot_strobe = snap_pulse;

    // every counted byte is kept, even ones dropped further on
    wire [31:0] tally_inc = {31'h0000_0000, abort_byte_inc};

    // byte arriving on the copy edge starts the new period
    wire [31:0] tally_d = snap_pulse ? tally_inc : (tally_q + tally_inc);

    logic snap_done_d;
    always_comb
    begin
        snap_done_d = snap_done_q;
        if (!snap_req_q)
        begin
            snap_done_d = 1'b0;
        end
        else if (snap_busy_q)
        begin
            snap_done_d = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tally_q <= 32'h0000_0000;
        end
        else
        begin
            tally_q <= tally_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tally_snap_q <= 32'h0000_0000;
        end
        else if (snap_pulse)
        begin
            tally_snap_q <= tally_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            snap_req_prev_q <= 1'b0;
        end
        else
        begin
            snap_req_prev_q <= snap_req_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            snap_busy_q <= 1'b0;
        end
        else
        begin
            snap_busy_q <= snap_pulse;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            snap_done_q <= 1'b0;
        end
        else
        begin
            snap_done_q <= snap_done_d;
        end
    end

    assign aborted_byte_tally_low = tally_snap_q[15:0];

    // header mismatch events
    srx_pkg::srx_flags_t x86_set;
    assign x86_set[`SRX_BIT_ADDR_MM] = hdr_valid && (hdr_address != expected_address);
    assign x86_set[`SRX_BIT_CTRL_MM] = hdr_valid && (hdr_control != expected_control);
    assign x86_set[`SRX_BIT_LSAPI_MM] =
        hdr_valid && (received_lower_sapi_octet != expected_lower_sapi);
    assign x86_set[`SRX_BIT_USAPI_MM] =
        hdr_valid && (received_upper_sapi_octet != expected_upper_sapi);

    // watermarks: value shifted by 16 equals value times 32 times 2048
    assign queue_low_mark_bytes = {low_mark_q, 16'h0000};
    assign queue_high_mark_bytes = {high_mark_q, 16'h0000};

    wire above_low = (txq_fill_level >= queue_low_mark_bytes);
    wire above_high = (txq_fill_level >= queue_high_mark_bytes);

    // a crossing in either direction counts
    srx_pkg::srx_flags_t txq_set;
    assign txq_set[`SRX_BIT_LOW_X] = above_low ^ above_low_q;
    assign txq_set[`SRX_BIT_HIGH_X] = above_high ^ above_high_q;
    assign txq_set[`SRX_BIT_Q_OVF] = txq_overflow;
    assign txq_set[`SRX_BIT_F_OVF] = staging_fifo_overflow;

    // clear-on-read per flag bit; set beats clear so no event is lost
    srx_pkg::srx_flags_t x86_flags_d;
    srx_pkg::srx_flags_t txq_flags_d;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_flag
            assign x86_flags_d[gi] = (x86_flags_q[gi] && !rd_x86_flags) || x86_set[gi];
            assign txq_flags_d[gi] = (txq_flags_q[gi] && !rd_txq_flags) || txq_set[gi];
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            x86_flags_q <= `SRX_RST_FLAGS;
            txq_flags_q <= `SRX_RST_FLAGS;
        end
        else
        begin
            x86_flags_q <= x86_flags_d;
            txq_flags_q <= txq_flags_d;
        end
    end

    // fill history starts as "below" so a queue already past a mark flags once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            above_low_q <= 1'b0;
        end
        else
        begin
            above_low_q <= above_low;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            above_high_q <= 1'b0;
        end
        else
        begin
            above_high_q <= above_high;
        end
    end

    // levels, not pulses: they drop on the read stall edge that clears the flag
    assign x86_irq = |(x86_flags_q & x86_en_q);
    assign txq_irq = |(txq_flags_q & txq_en_q);

endmodule : srx_regs

// file: verification/srx_regs_checker.sv
`timescale 1ns/100ps
module srx_regs_checker (
    // bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    // block outputs and events
    input wire logic hdr_valid,
    input wire logic [15:0] aborted_byte_tally_low,
    input wire logic perf_snapshot_strobe,
    input wire logic x86_irq,
    input wire logic [23:0] txq_fill_level,
    input wire logic txq_overflow,
    input wire logic staging_fifo_overflow,
    input wire logic [23:0] queue_low_mark_bytes,
    input wire logic [23:0] queue_high_mark_bytes,
    input wire logic txq_irq
);
    wire tk = hsel && htrans[1] && hready;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_read_one_stall: assert property (tk && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not two cycles");
    a_write_no_stall: assert property (tk && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    a_mark_units: assert property (
        (queue_low_mark_bytes[15:0] | queue_high_mark_bytes[15:0]) == 16'h0000)
        else $error("watermark not in whole units");
    a_mark_by_write: assert property (
        $changed(queue_low_mark_bytes) || $changed(queue_high_mark_bytes) |-> $past(tk && hwrite, 2))
        else $error("watermark moved without a write");
    a_strobe_one_pulse: assert property (
        perf_snapshot_strobe |-> $past(tk && hwrite, 2) ##1 !perf_snapshot_strobe)
        else $error("snapshot strobe without write or too long");
    a_tally_by_strobe: assert property ($changed(aborted_byte_tally_low) |-> $past(perf_snapshot_strobe))
        else $error("tally copy changed without snapshot");
    a_x86_irq_rise: assert property ($rose(x86_irq) |-> $past(hdr_valid) || $past(tk && hwrite, 2))
        else $error("header irq rose without cause");
    a_x86_irq_fall: assert property ($fell(x86_irq) |-> $past(tk, 2))
        else $error("header irq fell without access");
    a_txq_irq_rise: assert property ($rose(txq_irq) |-> $past(tk && hwrite, 2) || $past(tk && hwrite, 3)
        || $past(txq_overflow || staging_fifo_overflow) || $past(txq_fill_level) != $past(txq_fill_level, 2))
        else $error("queue irq rose without cause");
endmodule : srx_regs_checker
bind srx_regs srx_regs_checker u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .hdr_valid(hdr_valid),
    .aborted_byte_tally_low(aborted_byte_tally_low),
    .perf_snapshot_strobe(perf_snapshot_strobe),
    .x86_irq(x86_irq),
    .txq_fill_level(txq_fill_level),
    .txq_overflow(txq_overflow),
    .staging_fifo_overflow(staging_fifo_overflow),
    .queue_low_mark_bytes(queue_low_mark_bytes),
    .queue_high_mark_bytes(queue_high_mark_bytes),
    .txq_irq(txq_irq)
);

// file: verification/serial_rx_stats_txq_watermark_regs_bench.sv
`timescale 1ns/100ps
`include "srx_cfg.svh"
module serial_rx_stats_txq_watermark_regs_bench;
    logic hclk, hresetn, hsel, hwrite, abort_byte_inc, hdr_valid, txq_overflow, staging_fifo_overflow, rd_ph;
    logic hreadyout, hresp, perf_snapshot_strobe, x86_irq, txq_irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] hdr_address, hdr_control, received_upper_sapi_octet, received_lower_sapi_octet, lo, hi;
    logic [7:0] expected_address, expected_control, expected_upper_sapi, expected_lower_sapi;
    logic [23:0] txq_fill_level, queue_low_mark_bytes, queue_high_mark_bytes;
    logic [15:0] aborted_byte_tally_low;
    logic [23:0] fl [4] = '{24'h010000, 24'h020000, 24'h000000, 24'h000000};
    logic [7:0] fx [4] = '{8'h01, 8'h02, 8'h03, 8'h0c};
    wire hready = hreadyout;
    int n_mismatch = 0;
    int tests_run = 0;
    int n_strobe = 0;
    int k;
    logic [31:0] q[$];
    srx_regs DUT (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .abort_byte_inc(abort_byte_inc),
        .aborted_byte_tally_low(aborted_byte_tally_low),
        .perf_snapshot_strobe(perf_snapshot_strobe),
        .hdr_valid(hdr_valid),
        .hdr_address(hdr_address),
        .hdr_control(hdr_control),
        .received_upper_sapi_octet(received_upper_sapi_octet),
        .received_lower_sapi_octet(received_lower_sapi_octet),
        .expected_address(expected_address),
        .expected_control(expected_control),
        .expected_upper_sapi(expected_upper_sapi),
        .expected_lower_sapi(expected_lower_sapi),
        .x86_irq(x86_irq),
        .txq_fill_level(txq_fill_level),
        .txq_overflow(txq_overflow),
        .staging_fifo_overflow(staging_fifo_overflow),
        .queue_low_mark_bytes(queue_low_mark_bytes),
        .queue_high_mark_bytes(queue_high_mark_bytes),
        .txq_irq(txq_irq)
    );
    always #4 hclk = ~hclk;
    task report_and_stop;
        $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait so a stuck slave ends the run
    task wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            n_mismatch++;
            report_and_stop;
        end
    endtask : wait_rdy
    task bus(input logic [9:0] idx, input logic wr, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {20'h0, idx, 2'h0};
        wait_rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy;
    endtask : bus
    task rd(input logic [9:0] idx, input logic [7:0] e);
        q.push_back({24'h0, e});
        bus(idx, 1'b0, 8'h00);
    endtask : rd
    task hdr(input logic [1:0] b);
        hdr_valid <= 1'b1;
        hdr_address <= (b == 2'h0) ? ~expected_address : expected_address;
        hdr_control <= (b == 2'h1) ? ~expected_control : expected_control;
        received_lower_sapi_octet <= (b == 2'h2) ? ~expected_lower_sapi : expected_lower_sapi;
        received_upper_sapi_octet <= (b == 2'h3) ? ~expected_upper_sapi : expected_upper_sapi;
        @(posedge hclk);
        hdr_valid <= 1'b0;
    endtask : hdr
    always @(posedge hclk)
    begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1)
            chk(hrdata, q.pop_front());
        if (hreadyout === 1'b1)
            rd_ph <= hsel && htrans[1] && !hwrite;
    end
    // each request rise must give exactly one strobe cycle
    always @(posedge hclk)
    begin
        if (perf_snapshot_strobe === 1'b1)
            n_strobe++;
    end
    initial
    begin
        {hclk, hresetn, hsel, hwrite, abort_byte_inc, hdr_valid, txq_overflow, staging_fifo_overflow, rd_ph} = '0;
        {haddr, hwdata, htrans, hdr_address, hdr_control, received_upper_sapi_octet} = '0;
        {received_lower_sapi_octet, txq_fill_level} = '0;
        hsize = 3'h2;
        void'($urandom(57));
        {expected_address, expected_control, expected_upper_sapi, expected_lower_sapi} = $urandom;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // marks reset to zero, so both crossing flags latch once
        for (logic [9:0] i = 10'h11e; i <= 10'h127; i++)
            rd(i, (i == 10'h127) ? 8'h03 : 8'h00);
        bus(10'h100, 1'b1, 8'hff);
        rd(10'h100, 8'h00);
        lo = 8'($urandom) | 8'h01;
        hi = 8'($urandom) | 8'h01;
        bus(`SRX_IDX_TXQ_LOW, 1'b1, lo);
        bus(`SRX_IDX_TXQ_HIGH, 1'b1, hi);
        rd(`SRX_IDX_TXQ_LOW, lo);
        rd(`SRX_IDX_TXQ_HIGH, hi);
        chk({8'h0, queue_low_mark_bytes}, {8'h0, lo, 16'h0});
        chk({8'h0, queue_high_mark_bytes}, {8'h0, hi, 16'h0});
        rd(`SRX_IDX_TXQ_FLAGS, 8'h03);
        bus(`SRX_IDX_X86_IRQ_EN, 1'b1, 8'h05);
        rd(`SRX_IDX_X86_IRQ_EN, 8'h05);
        for (int b = 0; b < 4; b++)
        begin
            hdr(2'(b));
            @(posedge hclk);
            chk(32'(x86_irq), 32'(b % 2 == 0));
            rd(`SRX_IDX_X86_FLAGS, 8'h01 << b);
            chk(32'(x86_irq), 32'h0);
        end
        bus(`SRX_IDX_TXQ_LOW, 1'b1, 8'h01);
        bus(`SRX_IDX_TXQ_HIGH, 1'b1, 8'h02);
        bus(`SRX_IDX_TXQ_IRQ_EN, 1'b1, 8'h04);
        for (int i = 0; i < 4; i++)
        begin
            txq_fill_level <= fl[i];
            txq_overflow <= (i == 3);
            staging_fifo_overflow <= (i == 3);
            @(posedge hclk);
            txq_overflow <= 1'b0;
            staging_fifo_overflow <= 1'b0;
            repeat (2) @(posedge hclk);
            chk(32'(txq_irq), 32'(i == 3));
            rd(`SRX_IDX_TXQ_FLAGS, fx[i]);
        end
        chk(32'(txq_irq), 32'h0);
        // long enough to carry into the third tally byte; the top byte stays zero
        k = 32'h10000 + ($urandom % 256);
        abort_byte_inc <= 1'b1;
        repeat (k) @(posedge hclk);
        abort_byte_inc <= 1'b0;
        bus(`SRX_IDX_SNAP_REQ, 1'b1, 8'h01);
        repeat (3) @(posedge hclk);
        chk({16'h0, aborted_byte_tally_low}, k & 32'h0000ffff);
        rd(`SRX_IDX_ABORT_B2, 8'(k >> 16));
        rd(`SRX_IDX_ABORT_B3, 8'h00);
        rd(`SRX_IDX_SNAP_DONE, 8'h01);
        bus(`SRX_IDX_SNAP_DONE, 1'b1, 8'h00);
        bus(`SRX_IDX_SNAP_REQ, 1'b1, 8'h00);
        repeat (3) @(posedge hclk);
        rd(`SRX_IDX_SNAP_DONE, 8'h00);
        bus(`SRX_IDX_SNAP_REQ, 1'b1, 8'h01);
        repeat (3) @(posedge hclk);
        chk({16'h0, aborted_byte_tally_low}, 32'h0);
        rd(`SRX_IDX_ABORT_B2, 8'h00);
        repeat (4) @(posedge hclk);
        chk(32'(n_strobe), 32'h2);
        report_and_stop;
    end
endmodule : serial_rx_stats_txq_watermark_regs_bench
